// *** hdl/dlr_pkg.sv ***
// Purpose: shared constants and types for the display list render control block
// Assumes: 32-bit register port, 32-bit system memory word bus
// Notes:   offsets, fields, opcodes and reset values live here only
package dlr_pkg;

  // register word addresses
  localparam logic [3:0] ADDR_START   = 4'h0;  // list_start_address_reg
  localparam logic [3:0] ADDR_DIAG    = 4'h1;  // diagnostic_address_reg
  localparam logic [3:0] ADDR_EVENT   = 4'h2;  // render_event_reg
  localparam logic [3:0] ADDR_SRESET  = 4'h3;  // engine soft reset strobe
  localparam logic [3:0] ADDR_LIMIT   = 4'h4;  // legal address ceiling
  localparam logic [3:0] ADDR_BOOL    = 4'h5;  // boolean code readback

  // render_event_reg field positions
  localparam int EV_DONE   = 0;   // render_done_flag
  localparam int EV_ERROR  = 1;   // render_error_flag
  localparam int EV_ACTIVE = 2;   // render_active_flag
  localparam int EV_QUEUED = 3;   // list_queued_flag
  localparam int EN_DONE   = 8;   // done enable
  localparam int EN_ERROR  = 9;   // error enable
  localparam int SR_ENGINE = 0;   // engine bit in soft reset register

  // order opcodes, held in bits 31:24 of an opcode word
  localparam logic [7:0] OP_STOP  = 8'h00;  // end of list
  localparam logic [7:0] OP_NOP   = 8'h01;  // no operation
  localparam logic [7:0] OP_BOOL  = 8'h02;  // boolean_code_load_order, code in 7:0
  localparam logic [7:0] OP_BAND  = 8'h03;  // band header: addr, size, number follow
  localparam logic [7:0] OP_FILL  = 8'h04;  // banded fill: band, dst, count, src, ht
  localparam int       OPC_HI  = 31;
  localparam int       OPC_LO  = 24;
  localparam int       ROT_BIT = 23;        // fill order: rotated page flag

  // reset values
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [31:0] RST_LIMIT = 32'hFFFF_FFFF;
  localparam logic [7:0]  RST_BOOL  = 8'h00;

  // memory request kind
  typedef struct packed {
    logic        req;    // request pending
    logic        we;     // write when high
    logic [31:0] addr;   // byte address
    logic [31:0] wdata;  // write data
  } dlr_mem_req_t;

  // register port request
  typedef struct packed {
    logic        wr;     // write strobe
    logic        rd;     // read strobe
    logic [3:0]  addr;   // word address
    logic [31:0] wdata;  // write data
  } dlr_reg_req_t;

endpackage : dlr_pkg

// *** hdl/dlr_engine.sv ***
// Purpose: sequencing of display list fetch, events, error freeze and band fault write back
// Assumes: memory answers a request with mem_ack, read data valid in that cycle
// Notes:   one fill order renders one destination word per step; no buffering
`timescale 1ns/10ps
module dlr_engine #(
  parameter int ADDR_W = 32  // address width of the list and bitmaps
) (
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire logic                  clk_en,
  input  wire dlr_pkg::dlr_reg_req_t reg_req,
  output logic [31:0]                reg_rdata,
  output dlr_pkg::dlr_mem_req_t      mem_req,
  input  wire logic                  mem_ack,
  input  wire logic [31:0]           mem_rdata,
  input  wire logic [31:0]           left_mask,
  input  wire logic [31:0]           right_mask,
  output logic                       irq
);

  initial begin
    if (ADDR_W != 32) begin
      $error("dlr_engine: only 32-bit addresses are supported");
    end
  end

  // engine sequencer states
  typedef enum logic [3:0] {
    ST_IDLE,      // waiting for a list
    ST_FETCH,     // reading an opcode word
    ST_OPERAND,   // reading operand words into o0 to o4
    ST_EXEC,      // deciding what the order does
    ST_RDDST,     // reading destination word
    ST_RDSRC,     // reading source word
    ST_RDHT,      // reading halftone word
    ST_WRDST,     // writing combined word
    ST_WBACK,     // band fault write back
    ST_ERROR      // halted until soft reset
  } dlr_state_t;

  // whole module state
  typedef struct packed {
    dlr_state_t  st;
    logic [31:0] start;       // running list base
    logic [31:0] queued;      // second list address
    logic        done;        // render_done_flag
    logic        err;         // render_error_flag
    logic        active;      // render_active_flag
    logic        qflag;       // list_queued_flag
    logic        en_done;
    logic        en_err;
    logic [31:0] pc;          // fetch address
    logic [31:0] diag;        // diagnostic_address_reg
    logic [31:0] limit;       // highest legal byte address
    logic [7:0]  boolc;       // boolean code
    logic [7:0]  opc;         // current opcode
    logic        rot;         // rotated page order
    logic [31:0] op_base;     // address of current order
    logic [2:0]  opi;         // operand index
    logic [2:0]  opn;         // operand count
    logic [31:0] o0;          // band number / band addr
    logic [31:0] o1;          // dest addr / band size
    logic [31:0] o2;          // remaining word count / band number
    logic [31:0] o3;          // source addr
    logic [31:0] o4;          // halftone pattern addr
    logic [31:0] band_addr;   // current band bitmap base
    logic [31:0] band_size;   // band length in bytes
    logic [31:0] band_num;    // band selected for rendering
    logic [31:0] dw, sw, hw;  // pixel words
    logic [2:0]  wbi;         // write back index
    logic [31:0] rdata;
    logic        irq;
    dlr_pkg::dlr_mem_req_t m;
  } dlr_state_s_t;

  dlr_state_s_t s_r, s_nxt;

  // any byte address above the ceiling is out of range
  function automatic logic bad_addr(input logic [31:0] a, input logic [31:0] lim);
    return a > lim;
  endfunction

  // boolean combine of three operand words, code bit index = {h,s,d} per pixel
  function automatic logic [31:0] bool_mix(input logic [7:0] code, input logic [31:0] d,
                                           input logic [31:0] sv, input logic [31:0] h);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 32; i++) begin
      r[i] = code[{h[i], sv[i], d[i]}];
    end
    return r;
  endfunction

  // next-state logic for registers, sequencer and memory request
  always_comb begin
    logic        wr_start;
    logic [31:0] nxt_word, mix, keep;
    logic        list_end;
    s_nxt = s_r;
    wr_start = reg_req.wr && reg_req.addr == dlr_pkg::ADDR_START;
    list_end = 1'b0;
    nxt_word = '0;
    mix = '0;
    keep = '0;
    s_nxt.m.req = 1'b0;

    // register reads, data in the following cycle
    if (reg_req.rd) begin
      if (reg_req.addr == dlr_pkg::ADDR_START) begin
        s_nxt.rdata = s_r.start;
      end else if (reg_req.addr == dlr_pkg::ADDR_DIAG) begin
        s_nxt.rdata = s_r.diag;
      end else if (reg_req.addr == dlr_pkg::ADDR_EVENT) begin
        s_nxt.rdata = '0;
        s_nxt.rdata[dlr_pkg::EV_DONE]   = s_r.done;
        s_nxt.rdata[dlr_pkg::EV_ERROR]  = s_r.err;
        s_nxt.rdata[dlr_pkg::EV_ACTIVE] = s_r.active;
        s_nxt.rdata[dlr_pkg::EV_QUEUED] = s_r.qflag;
        s_nxt.rdata[dlr_pkg::EN_DONE]   = s_r.en_done;
        s_nxt.rdata[dlr_pkg::EN_ERROR]  = s_r.en_err;
      end else if (reg_req.addr == dlr_pkg::ADDR_LIMIT) begin
        s_nxt.rdata = s_r.limit;
      end else if (reg_req.addr == dlr_pkg::ADDR_BOOL) begin
        s_nxt.rdata = {24'h00_0000, s_r.boolc};
      end else begin
        s_nxt.rdata = '0;  // unmapped reads zero
      end
    end else begin
      s_nxt.rdata = '0;
    end

    // event write: ones clear the done and error flags, enables written directly
    if (reg_req.wr && reg_req.addr == dlr_pkg::ADDR_EVENT) begin
      if (reg_req.wdata[dlr_pkg::EV_DONE])  s_nxt.done = 1'b0;
      if (reg_req.wdata[dlr_pkg::EV_ERROR]) s_nxt.err  = 1'b0;
      s_nxt.en_done = reg_req.wdata[dlr_pkg::EN_DONE];
      s_nxt.en_err  = reg_req.wdata[dlr_pkg::EN_ERROR];
    end
    if (reg_req.wr && reg_req.addr == dlr_pkg::ADDR_LIMIT) begin
      s_nxt.limit = reg_req.wdata;
    end

    // start writes; an errored engine drops them
    if (wr_start && s_r.st != ST_ERROR) begin
      if (s_r.active) begin
        s_nxt.queued = reg_req.wdata;
        s_nxt.qflag  = 1'b1;
      end else begin
        s_nxt.start  = reg_req.wdata;
        s_nxt.pc     = reg_req.wdata;
        s_nxt.active = 1'b1;
        s_nxt.band_num = '0;
        s_nxt.st     = bad_addr(reg_req.wdata, s_r.limit) ? ST_ERROR : ST_FETCH;
        if (bad_addr(reg_req.wdata, s_r.limit)) s_nxt.err = 1'b1;
      end
    end

    // diagnostic follows the interpreted address until an error freezes it
    if (s_r.st != ST_ERROR && s_r.st != ST_IDLE) begin
      s_nxt.diag = s_r.pc;
    end

    // sequencer
    case (s_r.st)
      ST_IDLE: begin
      end
      ST_FETCH: begin
        s_nxt.m.req = 1'b1;
        s_nxt.m.we = 1'b0;
        s_nxt.m.addr = s_r.pc;
        if (s_r.m.req && mem_ack) begin
          s_nxt.m.req = 1'b0;
          s_nxt.opc = mem_rdata[dlr_pkg::OPC_HI:dlr_pkg::OPC_LO];
          s_nxt.rot = mem_rdata[dlr_pkg::ROT_BIT];
          s_nxt.op_base = s_r.pc;
          s_nxt.pc = s_r.pc + 32'h0000_0004;
          s_nxt.opi = '0;
          case (mem_rdata[dlr_pkg::OPC_HI:dlr_pkg::OPC_LO])
            dlr_pkg::OP_STOP: list_end = 1'b1;
            dlr_pkg::OP_NOP: s_nxt.st = ST_FETCH;
            dlr_pkg::OP_BOOL: s_nxt.boolc = mem_rdata[7:0];
            dlr_pkg::OP_BAND: begin
              s_nxt.opn = 3'd3;
              s_nxt.st = ST_OPERAND;
            end
            dlr_pkg::OP_FILL: begin
              s_nxt.opn = 3'd5;
              s_nxt.st = ST_OPERAND;
            end
            default: begin
              s_nxt.err = 1'b1;
              s_nxt.st = ST_ERROR;
            end
          endcase
        end
      end
      ST_OPERAND: begin
        s_nxt.m.req = 1'b1;
        s_nxt.m.we = 1'b0;
        s_nxt.m.addr = s_r.pc;
        if (s_r.m.req && mem_ack) begin
          s_nxt.m.req = 1'b0;
          s_nxt.pc = s_r.pc + 32'h0000_0004;
          s_nxt.opi = s_r.opi + 3'd1;
          case (s_r.opi)
            3'd0: s_nxt.o0 = mem_rdata;
            3'd1: s_nxt.o1 = mem_rdata;
            3'd2: s_nxt.o2 = mem_rdata;
            3'd3: s_nxt.o3 = mem_rdata;
            default: s_nxt.o4 = mem_rdata;
          endcase
          if (s_r.opi + 3'd1 == s_r.opn) s_nxt.st = ST_EXEC;
        end
      end
      ST_EXEC: begin
        // bounds checked per word: a fault may cut an order
        if (s_r.opc == dlr_pkg::OP_BAND) begin
          s_nxt.band_addr = s_r.o0;
          s_nxt.band_size = s_r.o1;
          s_nxt.band_num  = s_r.o2;
          s_nxt.st = ST_FETCH;
        end else if (s_r.o0 != s_r.band_num || s_r.o2 == '0) begin
          s_nxt.st = ST_FETCH;       // order belongs to another band or has no words left
        end else if (bad_addr(s_r.o3, s_r.limit) || bad_addr(s_r.o4, s_r.limit)) begin
          s_nxt.err = 1'b1;
          s_nxt.st = ST_ERROR;
        end else if (s_r.o1 >= s_r.band_size) begin
          s_nxt.wbi = '0;            // destination past the band: fault
          s_nxt.st = ST_WBACK;
        end else begin
          s_nxt.st = ST_RDDST;
        end
      end
      ST_RDDST, ST_RDSRC, ST_RDHT: begin
        s_nxt.m.req = 1'b1;
        s_nxt.m.we = 1'b0;
        s_nxt.m.addr = (s_r.st == ST_RDDST) ? s_r.band_addr + s_r.o1 :
                       (s_r.st == ST_RDSRC) ? s_r.o3 : s_r.o4;
        if (s_r.m.req && mem_ack) begin
          s_nxt.m.req = 1'b0;
          if (s_r.st == ST_RDDST) begin
            s_nxt.dw = mem_rdata;
            s_nxt.st = ST_RDSRC;
          end else if (s_r.st == ST_RDSRC) begin
            s_nxt.sw = mem_rdata;
            s_nxt.st = ST_RDHT;
          end else begin
            s_nxt.hw = mem_rdata;
            s_nxt.st = ST_WRDST;
          end
        end
      end
      ST_WRDST: begin
        // masks pick pixels inside the rectangle; the rest keep old destination
        mix = bool_mix(s_r.boolc, s_r.dw, s_r.sw, s_r.hw);
        keep = left_mask & right_mask;
        s_nxt.m.req = 1'b1;
        s_nxt.m.we = 1'b1;
        s_nxt.m.addr = s_r.band_addr + s_r.o1;
        s_nxt.m.wdata = (mix & keep) | (s_r.dw & ~keep);
        if (s_r.m.req && mem_ack) begin
          s_nxt.m.req = 1'b0;
          s_nxt.o1 = s_r.o1 + 32'h0000_0004;
          s_nxt.o3 = s_r.o3 + 32'h0000_0004;
          s_nxt.o2 = s_r.o2 - 32'h0000_0001;
          s_nxt.st = ST_EXEC;
        end
      end
      ST_WBACK: begin
        // resume point goes back over the order: band, dest offset, count, source
        nxt_word = s_r.rot ? s_r.o0 - 32'h0000_0001 : s_r.o0 + 32'h0000_0001;
        s_nxt.m.req = 1'b1;
        s_nxt.m.we = 1'b1;
        s_nxt.m.addr = s_r.op_base + 32'h0000_0004 + {27'h000_0000, s_r.wbi, 2'b00};
        case (s_r.wbi)
          3'd0: s_nxt.m.wdata = nxt_word;
          3'd1: s_nxt.m.wdata = s_r.o1 - s_r.band_size;
          3'd2: s_nxt.m.wdata = s_r.o2;
          default: s_nxt.m.wdata = s_r.o3;
        endcase
        if (s_r.m.req && mem_ack) begin
          s_nxt.m.req = 1'b0;
          s_nxt.wbi = s_r.wbi + 3'd1;
          if (s_r.wbi == 3'd3) s_nxt.st = ST_FETCH;  // next order
        end
      end
      default: begin  // ST_ERROR: busy and queued untouched
        s_nxt.m.req = 1'b0;
      end
    endcase

    // list finished: done event, then queued list or idle
    if (list_end) begin
      s_nxt.done = 1'b1;
      if (s_r.qflag) begin
        s_nxt.qflag = 1'b0;
        s_nxt.start = s_r.queued;
        s_nxt.pc = s_r.queued;
        s_nxt.band_num = '0;
        if (bad_addr(s_r.queued, s_r.limit)) begin
          s_nxt.err = 1'b1;
          s_nxt.st = ST_ERROR;
        end else begin
          s_nxt.st = ST_FETCH;
        end
      end else begin
        s_nxt.active = 1'b0;
        s_nxt.st = ST_IDLE;
      end
    end

    // a request in flight is dropped, no answer awaited
    // engine soft reset wins over everything else
    if (reg_req.wr && reg_req.addr == dlr_pkg::ADDR_SRESET &&
        reg_req.wdata[dlr_pkg::SR_ENGINE]) begin
      s_nxt.start  = dlr_pkg::RST_WORD;
      s_nxt.queued = dlr_pkg::RST_WORD;
      s_nxt.active = 1'b0;
      s_nxt.qflag  = 1'b0;
      s_nxt.diag   = dlr_pkg::RST_WORD;
      s_nxt.boolc  = dlr_pkg::RST_BOOL;
      s_nxt.st     = ST_IDLE;
      s_nxt.m.req  = 1'b0;
    end

    // request line follows flags and enables
    s_nxt.irq = (s_nxt.done & s_nxt.en_done) | (s_nxt.err & s_nxt.en_err);
  end

  // open ceiling after reset: any start is in range
  // single state register; clock enable freezes all of it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.limit <= dlr_pkg::RST_LIMIT;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // every output is a field of the state register
  assign reg_rdata = s_r.rdata;
  assign mem_req   = s_r.m;
  assign irq       = s_r.irq;

endmodule // dlr_engine

// *** tb/dlr_checker.sv ***
// Purpose: port assertions for the display list render engine
// Assumes: sees only the engine ports; bound from the bench top
// Notes:   helper logic mirrors the ceiling, the enables and a known idle state
`timescale 1ns/10ps
module dlr_checker (
  input wire logic                  clock,
  input wire logic                  resetn,
  input wire logic                  clk_en,
  input wire dlr_pkg::dlr_reg_req_t reg_req,
  input wire logic [31:0]           reg_rdata,
  input wire dlr_pkg::dlr_mem_req_t mem_req,
  input wire logic                  mem_ack,
  input wire logic [31:0]           mem_rdata,
  input wire logic [31:0]           left_mask,
  input wire logic [31:0]           right_mask,
  input wire logic                  irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  logic        wr_c;     // write taken this cycle
  logic        st_c;     // start write taken this cycle
  logic        rd_ev_q;  // event word answered this cycle
  logic        idle_r;   // engine seen idle, no start since
  logic [31:0] lim_r;    // mirror of the address ceiling
  logic [1:0]  en_r;     // mirror of the two enables
  assign wr_c = reg_req.wr && clk_en;
  assign st_c = wr_c && reg_req.addr == dlr_pkg::ADDR_START;
  // mirrors; idle is only known from a read, so any start write drops it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rd_ev_q <= 1'b0;
      idle_r  <= 1'b0;
      lim_r   <= dlr_pkg::RST_LIMIT;
      en_r    <= 2'b00;
    end else begin
      rd_ev_q <= reg_req.rd && clk_en && reg_req.addr == dlr_pkg::ADDR_EVENT;
      if (st_c) begin
        idle_r <= 1'b0;
      end else if (rd_ev_q) begin
        idle_r <= !reg_rdata[dlr_pkg::EV_ACTIVE] && !reg_rdata[dlr_pkg::EV_ERROR];
      end
      if (wr_c && reg_req.addr == dlr_pkg::ADDR_LIMIT) begin
        lim_r <= reg_req.wdata;
      end
      if (wr_c && reg_req.addr == dlr_pkg::ADDR_EVENT) begin
        en_r <= {reg_req.wdata[dlr_pkg::EN_ERROR], reg_req.wdata[dlr_pkg::EN_DONE]};
      end
    end
  end
  start_fetch_a: assert property (idle_r && st_c && reg_req.wdata <= lim_r ##1 clk_en ##1 clk_en
    |-> mem_req.req && mem_req.addr == $past(reg_req.wdata, 2)) else $error("no fetch at start");
  idle_quiet_a: assert property (idle_r |-> !mem_req.req) else $error("request while idle");
  mem_hold_a: assert property (mem_req.req && !mem_ack |=> $stable(mem_req))
    else $error("memory request changed before answer");
  req_gap_a: assert property (mem_ack |=> !mem_req.req) else $error("request right after answer");
  rdata_zero_a: assert property (clk_en && !reg_req.rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside answer");
  unmapped_zero_a: assert property (reg_req.rd && clk_en && reg_req.addr > dlr_pkg::ADDR_BOOL
    |=> reg_rdata == 32'h0000_0000) else $error("unmapped read not zero");
  limit_read_a: assert property (reg_req.rd && clk_en && reg_req.addr == dlr_pkg::ADDR_LIMIT
    |=> reg_rdata == lim_r) else $error("ceiling readback wrong");
  irq_match_a: assert property (rd_ev_q && $stable(irq) |-> irq ==
    ((reg_rdata[0] && reg_rdata[8]) || (reg_rdata[1] && reg_rdata[9])))
    else $error("irq disagrees with event word");
  irq_masked_a: assert property (en_r == 2'b00 && $past(en_r) == 2'b00 |-> !irq)
    else $error("irq with enables off");
  diag_purge_a: assert property (wr_c && reg_req.addr == dlr_pkg::ADDR_SRESET && reg_req.wdata[0]
    ##2 (reg_req.rd && clk_en && reg_req.addr == dlr_pkg::ADDR_DIAG) |=> reg_rdata == 32'h0000_0000)
    else $error("diag not cleared by soft reset");
  cv_start_c: cover property (idle_r && st_c);
  cv_ack_c: cover property (mem_ack && mem_req.we);
  cv_irq_c: cover property ($rose(irq));
endmodule // dlr_checker

// *** tb/dlr_mem_model.sv ***
// Purpose: behavioural system memory on the far side of the engine
// Assumes: one request at a time, words picked by byte address bits 11:2
// Notes:   latency set by the bench; read data scrambles outside answers
`timescale 1ns/10ps
module dlr_mem_model (
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire dlr_pkg::dlr_mem_req_t mem_req,
  input  wire logic [3:0]            lat,
  output logic                       mem_ack,
  output logic [31:0]                mem_rdata
);
  logic [31:0] mem [0:1023];  // storage, preloaded by the bench
  logic [3:0]  cnt;           // cycles waited on the current request
  // plain always: the bench also writes the array directly
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mem_ack   <= 1'b0;
      cnt       <= 4'h0;
      mem_rdata <= 32'h0000_0000;
    end else if (!mem_ack && mem_req.req && cnt >= lat) begin
      mem_ack <= 1'b1;
      cnt     <= 4'h0;
      if (mem_req.we) begin
        mem[mem_req.addr[11:2]] <= mem_req.wdata;  // write back lands here
        mem_rdata               <= ~mem_rdata;
      end else begin
        mem_rdata <= mem[mem_req.addr[11:2]];
      end
    end else begin
      // no valid data outside an answer, so show a changing pattern
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req.req && !mem_ack) begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule // dlr_mem_model

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for the display list render engine
// Assumes: register port master tasks, memory model as far side
// Notes:   lists are preloaded into the memory model before each start
`timescale 1ns/10ps
module tb_top;
  logic                  clock;
  logic                  resetn;
  logic                  clk_en;
  dlr_pkg::dlr_reg_req_t reg_req;
  logic [31:0]           reg_rdata;
  dlr_pkg::dlr_mem_req_t mem_req;
  logic                  mem_ack;
  logic [31:0]           mem_rdata;
  logic [31:0]           left_mask;
  logic [31:0]           right_mask;
  logic                  irq;
  logic [3:0]            lat;
  int                    errors;
  int                    n_tests;
  logic [31:0]           v;
  logic [31:0]           d0;
  logic [31:0]           o;
  logic [31:0]           act;
  logic [31:0]           que;
  logic [31:0]           dn;
  logic [31:0]           er;
  dlr_engine uut (.clock, .resetn, .clk_en, .reg_req, .reg_rdata, .mem_req, .mem_ack,
    .mem_rdata, .left_mask, .right_mask, .irq);
  dlr_mem_model mem (.clock, .resetn, .mem_req, .lat, .mem_ack, .mem_rdata);
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // register writes and reads, one strobe cycle each
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_req.wr    <= 1'b1;
    reg_req.addr  <= a;
    reg_req.wdata <= d;
    @(posedge clock);
    reg_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_req.rd   <= 1'b1;
    reg_req.addr <= a;
    @(posedge clock);
    reg_req.rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic evc(input string n, input logic [31:0] m, input logic [31:0] e);
    rd(dlr_pkg::ADDR_EVENT, v);
    chk(n, e, v & m);
  endtask
  task automatic put(input logic [31:0] a, input logic [31:0] d);
    mem.mem[a[11:2]] = d;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // bounded poll of the event word; running out ends the run
  task automatic poll(input logic [31:0] m, input logic [31:0] e);
    rd(dlr_pkg::ADDR_EVENT, v);
    for (int i = 0; i < 400 && (v & m) !== e; i++) begin
      rd(dlr_pkg::ADDR_EVENT, v);
    end
    if ((v & m) !== e) begin
      errors++;
      $display("ERROR poll expected %h seen %h", e, v & m);
      close_out();
    end
  endtask
  initial begin
    act = 32'h0000_0001 << dlr_pkg::EV_ACTIVE;
    que = 32'h0000_0001 << dlr_pkg::EV_QUEUED;
    dn = 32'h0000_0001 << dlr_pkg::EV_DONE;
    er = 32'h0000_0001 << dlr_pkg::EV_ERROR;
    reg_req = '0;
    clk_en = 1'b1;
    lat = 4'h0;
    left_mask = 32'hFFFF_FF00;
    right_mask = 32'h00FF_FFFF;
    errors = 0;
    n_tests = 0;
    resetn = 1'b0;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    evc("event reset", 32'hFFFF_FFFF, 32'h0000_0000);
    rd(dlr_pkg::ADDR_LIMIT, v);
    chk("limit reset", dlr_pkg::RST_LIMIT, v);
    rd(4'hF, v);
    chk("unmapped", 32'h0000_0000, v);
    $display("test reset_values done");
    put(32'h0000_0100, {dlr_pkg::OP_NOP, 24'h00_0000});
    put(32'h0000_0104, {dlr_pkg::OP_BOOL, 16'h0000, 8'hA5});
    put(32'h0000_0108, {dlr_pkg::OP_STOP, 24'h00_0000});
    wr(dlr_pkg::ADDR_EVENT, 32'h0000_0001 << dlr_pkg::EN_DONE);
    wr(dlr_pkg::ADDR_START, 32'h0000_0100);
    poll(act, 32'h0000_0000);
    chk("done set", dn, v & (dn | er | que));
    chk("irq on", 32'h0000_0001, {31'h0, irq});
    rd(dlr_pkg::ADDR_BOOL, v);
    chk("bool code", 32'h0000_00A5, v);
    wr(dlr_pkg::ADDR_EVENT, (32'h0000_0001 << dlr_pkg::EN_DONE) | dn);
    evc("done clear", dn, 32'h0000_0000);
    chk("irq off", 32'h0000_0000, {31'h0, irq});
    $display("test single_list done");
    lat <= 4'h5;
    put(32'h0000_0200, {dlr_pkg::OP_BOOL, 16'h0000, 8'h11});
    put(32'h0000_0204, {dlr_pkg::OP_STOP, 24'h00_0000});
    for (int k = 0; k < 4; k++) begin
      put(32'h0000_0300 + 32'(k) * 32'h0000_0004, {dlr_pkg::OP_NOP, 24'h00_0000});
    end
    put(32'h0000_0310, {dlr_pkg::OP_BOOL, 16'h0000, 8'h3C});
    put(32'h0000_0314, {dlr_pkg::OP_STOP, 24'h00_0000});
    wr(dlr_pkg::ADDR_START, 32'h0000_0100);
    wr(dlr_pkg::ADDR_START, 32'h0000_0200);
    evc("queued set", act | que, act | que);
    wr(dlr_pkg::ADDR_START, 32'h0000_0300);
    poll(act | que, act);
    wr(dlr_pkg::ADDR_EVENT, 32'h0000_0000 | dn);
    evc("reread", dn | act, act);
    poll(act, 32'h0000_0000);
    chk("second done", dn, v & dn);
    rd(dlr_pkg::ADDR_BOOL, v);
    chk("queued list ran", 32'h0000_003C, v);
    $display("test queued_lists done");
    lat <= 4'h2;
    put(32'h0000_0500, {dlr_pkg::OP_BAND, 24'h00_0000});
    put(32'h0000_0504, 32'h0000_0800);
    put(32'h0000_0508, 32'h0000_0010);
    put(32'h0000_050C, 32'h0000_0002);
    for (int k = 0; k < 2; k++) begin
      o = 32'h0000_0510 + 32'(k) * 32'h0000_0018;
      put(o, {dlr_pkg::OP_FILL, k[0], 23'h00_0000});
      put(o + 32'h0000_0004, 32'h0000_0002);
      put(o + 32'h0000_0008, 32'h0000_0010 + 32'(k) * 32'h0000_0002);
      put(o + 32'h0000_000C, 32'h0000_0003);
      put(o + 32'h0000_0010, 32'h0000_0900);
      put(o + 32'h0000_0014, 32'h0000_0A00);
    end
    put(32'h0000_0540, {dlr_pkg::OP_STOP, 24'h00_0000});
    wr(dlr_pkg::ADDR_EVENT, dn);
    wr(dlr_pkg::ADDR_START, 32'h0000_0500);
    poll(act, 32'h0000_0000);
    chk("band list done", dn, v & (dn | er));
    for (int k = 0; k < 2; k++) begin
      o = 32'h0000_0514 + 32'(k) * 32'h0000_0018;
      chk("band number", (k == 1) ? 32'h0000_0001 : 32'h0000_0003, mem.mem[o[11:2]]);
      chk("resume offset", 32'(k) * 32'h0000_0002, mem.mem[o[11:2] + 10'h1]);
      chk("resume count", 32'h0000_0003, mem.mem[o[11:2] + 10'h2]);
      chk("resume source", 32'h0000_0900, mem.mem[o[11:2] + 10'h3]);
    end
    put(32'h0000_050C, 32'h0000_0003);
    put(32'h0000_0A00, 32'hF0F0_F0F0);
    for (int k = 0; k < 3; k++) begin
      mem.mem[10'h200 + 10'(k)] = 32'hAAAA_AAAA;
      mem.mem[10'h240 + 10'(k)] = 32'hCCCC_CCCC;
    end
    wr(dlr_pkg::ADDR_START, 32'h0000_0500);
    poll(act, 32'h0000_0000);
    for (int k = 0; k < 3; k++) begin
      chk("render word", 32'hAA3C_3CAA, mem.mem[10'h200 + 10'(k)]);
    end
    $display("test band_fault done");
    lat <= 4'h0;
    wr(dlr_pkg::ADDR_LIMIT, 32'h0000_0FFF);
    wr(dlr_pkg::ADDR_EVENT, (32'h0000_0001 << dlr_pkg::EN_ERROR) | dn);
    put(32'h0000_0400, {dlr_pkg::OP_NOP, 24'h00_0000});
    put(32'h0000_0404, 32'hFF00_0000);
    put(32'h0000_0408, {dlr_pkg::OP_NOP, 24'h00_0000});
    put(32'h0000_040C, {dlr_pkg::OP_STOP, 24'h00_0000});
    wr(dlr_pkg::ADDR_START, 32'h0000_0400);
    poll(er, er);
    chk("busy held", act, v & (act | que));
    chk("irq error", 32'h0000_0001, {31'h0, irq});
    wr(dlr_pkg::ADDR_START, 32'h0000_0100);
    evc("start dropped", act | que, act);
    rd(dlr_pkg::ADDR_DIAG, d0);
    chk("diag range", 32'h0000_0001, {31'h0, d0 >= 32'h0000_0404 && d0 <= 32'h0000_0410});
    repeat (20) @(posedge clock);
    rd(dlr_pkg::ADDR_DIAG, v);
    chk("diag frozen", d0, v);
    wr(dlr_pkg::ADDR_SRESET, 32'h0000_0001 << dlr_pkg::SR_ENGINE);
    rd(dlr_pkg::ADDR_DIAG, v);
    chk("diag purged", 32'h0000_0000, v);
    evc("flags purged", act | que, 32'h0000_0000);
    rd(dlr_pkg::ADDR_START, v);
    chk("start purged", 32'h0000_0000, v);
    rd(dlr_pkg::ADDR_BOOL, v);
    chk("bool purged", 32'h0000_0000, v);
    wr(dlr_pkg::ADDR_EVENT, er | dn);
    repeat (30) @(posedge clock);
    evc("dropped list idle", er | dn | act, 32'h0000_0000);
    wr(dlr_pkg::ADDR_START, 32'h0000_0100);
    poll(act, 32'h0000_0000);
    rd(dlr_pkg::ADDR_DIAG, v);
    chk("diag tracks", 32'h0000_0001, {31'h0, v !== 32'h0000_0000});
    wr(dlr_pkg::ADDR_START, 32'h0000_2000);
    poll(er, er);
    chk("no fetch", 32'h0000_0000, {31'h0, mem_req.req});
    $display("test error_recovery done");
    close_out();
  end
endmodule // tb_top
bind dlr_engine dlr_checker chk_i (.clock, .resetn, .clk_en, .reg_req, .reg_rdata, .mem_req,
  .mem_ack, .mem_rdata, .left_mask, .right_mask, .irq);
